// [core/ehci_cmd_pkg.sv]
/*
 * Constants shared by the command/interrupt control block: register offsets,
 * field positions, reset values and threshold encodings.
 * Assumes a 32-bit APB register bus with byte addresses.
 */
package ehci_cmd_pkg;

    // ==========================================================================
    // Register offsets
    // ==========================================================================
    localparam logic [7:0] CMD_OFF       = 8'h20;
    localparam logic [7:0] STATUS_OFF    = 8'h24;
    localparam logic [7:0] IRQ_EN_OFF    = 8'h28;

    // ==========================================================================
    // Field positions
    // ==========================================================================
    localparam int THR_LSB              = 16;
    localparam int THR_MSB              = 23;
    localparam int LRESET_BIT           = 7;
    localparam int DOORBELL_BIT         = 6;
    localparam int HALTED_BIT           = 12;
    localparam int ADV_FLAG_BIT         = 5;
    localparam int ADV_EN_BIT           = 5;

    // ==========================================================================
    // Reset values and threshold encodings
    // ==========================================================================
    localparam logic [7:0] THR_RESET    = 8'h08;
    localparam logic [7:0] THR_1UF      = 8'h01;
    localparam logic [7:0] THR_2UF      = 8'h02;
    localparam logic [7:0] THR_4UF      = 8'h04;
    localparam logic [7:0] THR_8UF      = 8'h08;
    localparam logic [7:0] THR_16UF     = 8'h10;
    localparam logic [7:0] THR_32UF     = 8'h20;
    localparam logic [7:0] THR_64UF     = 8'h40;

endpackage : ehci_cmd_pkg

// [core/irq_threshold_timer.sv]
/*
 * Microframe counter that marks interrupt threshold boundaries.
 * Assumes one uframe_tick pulse per elapsed microframe from the frame timer.
 */
`timescale 1ns/1ps
module irq_threshold_timer
    import ehci_cmd_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       restart,
    // Timing
    input  wire logic       uframe_tick,
    input  wire logic [7:0] irq_threshold_sel,
    output logic            boundary
);

    logic [7:0] count;
    logic [7:0] limit;

    // The reserved encoding 00h behaves as one microframe rather than never firing.
    assign limit    = (irq_threshold_sel == 8'h00) ? THR_1UF : irq_threshold_sel;
    assign boundary = uframe_tick && (count + 8'h01 >= limit);

    // ==========================================================================
    // Counter
    // ==========================================================================
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            count <= 8'h00;
        else if (restart || boundary)
            count <= 8'h00;
        else if (uframe_tick)
            count <= count + 8'h01;
    end

endmodule : irq_threshold_timer

// [core/ehci_command_irq_control.sv]
/*
 * Interrupt threshold, light controller reset and async-advance doorbell
 * logic of the host command register, with the related status and enable bits,
 * behind an APB slave.
 * Assumes the schedule engine reports cache eviction and light-reset completion
 * as one-cycle pulses and the frame timer gives one pulse per microframe.
 */
// Design decisions made here: the APB slave port and the register addresses.
// Operation
// R1: Threshold field picks maximum interrupt rate.
// R2: Software changes threshold only while halted.
// R3: Light reset spares ports and companion routing.
// R4: Unimplemented light reset always reads zero.
// R5: Light reset bit reads one while busy.
// R6: Software writes one to ring doorbell.
// R7: Set advance flag after cache eviction.
// R8: Flag with enable raises interrupt at boundary.
// R9: No doorbell while async schedule inactive.
// R10: Threshold bits 23:16, reset 08h, small encodings.
// R11: Reserved command bits written as zero.
// R12: Hold interrupts until threshold boundary elapses.
`timescale 1ns/1ps
module ehci_command_irq_control
    import ehci_cmd_pkg::*;
#(
    parameter bit LIGHT_RESET_IMPL = 1'b1
)
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Schedule engine
    input  wire logic        ctrl_halted_flag,
    input  wire logic        async_cache_evicted,
    input  wire logic        uframe_tick,
    output logic             doorbell_pending,
    // Light reset handshake
    output logic             light_reset_req,
    input  wire logic        light_reset_done,
    // Interrupt
    output logic             host_irq
);

    logic [7:0] irq_threshold_sel;
    logic       async_advance_doorbell;
    logic       light_ctrl_reset;
    logic       async_advance_flag;
    logic       async_advance_irq_en;
    logic       boundary;
    logic       wr_en;
    logic       rd_en;
    logic       mapped;
    logic       light_clear;
    logic [31:0] next_rdata;

    assign wr_en           = psel && penable && pwrite;
    assign rd_en           = psel && !penable && !pwrite;
    assign mapped          = (paddr == CMD_OFF) || (paddr == STATUS_OFF) || (paddr == IRQ_EN_OFF);
    assign pready          = 1'b1;
    assign pslverr         = psel && penable && !mapped;
    assign doorbell_pending = async_advance_doorbell;
    assign light_reset_req = light_ctrl_reset;
    // Completion of a light reset returns the command state to its reset values.
    assign light_clear     = light_ctrl_reset && light_reset_done; // R3

    // ==========================================================================
    // Threshold field
    // ==========================================================================
    // Any value is stored; only the documented encodings have defined timing.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            irq_threshold_sel <= THR_RESET; // R10
        else if (light_clear)
            irq_threshold_sel <= THR_RESET; // R3
        else if (wr_en && paddr == CMD_OFF)
            irq_threshold_sel <= pwdata[THR_MSB:THR_LSB]; // R1 R2
    end

    // ==========================================================================
    // Light reset
    // ==========================================================================
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            light_ctrl_reset <= 1'b0;
        else if (!LIGHT_RESET_IMPL)
            light_ctrl_reset <= 1'b0; // R4
        else if (light_reset_done)
            light_ctrl_reset <= 1'b0; // R5
        else if (wr_en && paddr == CMD_OFF && pwdata[LRESET_BIT])
            light_ctrl_reset <= 1'b1; // R5
    end

    // ==========================================================================
    // Doorbell and advance flag
    // ==========================================================================
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            async_advance_doorbell <= 1'b0;
        else if (light_clear || (async_advance_doorbell && async_cache_evicted))
            async_advance_doorbell <= 1'b0; // R7
        else if (wr_en && paddr == CMD_OFF && pwdata[DOORBELL_BIT])
            async_advance_doorbell <= 1'b1; // R6
    end

    // Write one clears; a setting event in the same cycle wins.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            async_advance_flag <= 1'b0;
        else if (async_advance_doorbell && async_cache_evicted)
            async_advance_flag <= 1'b1; // R7
        else if (light_clear)
            async_advance_flag <= 1'b0;
        else if (wr_en && paddr == STATUS_OFF && pwdata[ADV_FLAG_BIT])
            async_advance_flag <= 1'b0;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            async_advance_irq_en <= 1'b0;
        else if (light_clear)
            async_advance_irq_en <= 1'b0;
        else if (wr_en && paddr == IRQ_EN_OFF)
            async_advance_irq_en <= pwdata[ADV_EN_BIT];
    end

    // ==========================================================================
    // Interrupt pacing
    // ==========================================================================
    irq_threshold_timer u_timer
    (
        .clk               (clk),
        .resetn            (resetn),
        .restart           (light_clear),
        .uframe_tick       (uframe_tick),
        .irq_threshold_sel (irq_threshold_sel),
        .boundary          (boundary)
    );

    // A pending condition waits for the boundary; clearing the cause drops it at once.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            host_irq <= 1'b0;
        else if (!(async_advance_flag && async_advance_irq_en))
            host_irq <= 1'b0;
        else if (boundary)
            host_irq <= 1'b1; // R8 R12
    end

    // ==========================================================================
    // Read data
    // ==========================================================================
    // Reserved bits read zero, matching what software must write back.
    always_comb
    begin
        next_rdata = 32'h0000_0000; // R11
        case (paddr)
            CMD_OFF:
            begin
                next_rdata[THR_MSB:THR_LSB] = irq_threshold_sel;
                next_rdata[LRESET_BIT]      = light_ctrl_reset && LIGHT_RESET_IMPL; // R4
                next_rdata[DOORBELL_BIT]    = async_advance_doorbell;
            end
            STATUS_OFF:
            begin
                next_rdata[HALTED_BIT]   = ctrl_halted_flag;
                next_rdata[ADV_FLAG_BIT] = async_advance_flag;
            end
            IRQ_EN_OFF:
                next_rdata[ADV_EN_BIT] = async_advance_irq_en;
            default:
                next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            prdata <= 32'h0000_0000;
        else if (rd_en)
            prdata <= next_rdata;
    end

    // ==========================================================================
    // Checks
    // ==========================================================================
    chk_thr_write: assert property (@(posedge clk) disable iff (!resetn)
        wr_en && paddr == CMD_OFF && !light_clear |=> irq_threshold_sel == $past(pwdata[THR_MSB:THR_LSB])) // R1
        else $error("threshold field did not take written value");
    chk_thr_reset: assert property (@(posedge clk) disable iff (!resetn)
        light_clear |=> irq_threshold_sel == THR_RESET) // R10
        else $error("threshold not restored by light reset");
    chk_lreset_zero: assert property (@(posedge clk) disable iff (!resetn)
        !LIGHT_RESET_IMPL |-> !light_ctrl_reset) // R4
        else $error("light reset reads one while absent");
    chk_lreset_busy: assert property (@(posedge clk) disable iff (!resetn)
        light_ctrl_reset && !light_reset_done |=> light_ctrl_reset) // R5
        else $error("light reset bit dropped before completion");
    chk_lreset_done: assert property (@(posedge clk) disable iff (!resetn)
        light_reset_done |=> !light_ctrl_reset) // R5
        else $error("light reset bit stuck after completion");
    chk_adv_set: assert property (@(posedge clk) disable iff (!resetn)
        async_advance_doorbell && async_cache_evicted |=> async_advance_flag && !async_advance_doorbell) // R7
        else $error("advance flag not set after eviction");
    chk_doorbell_ring: assert property (@(posedge clk) disable iff (!resetn)
        wr_en && paddr == CMD_OFF && pwdata[DOORBELL_BIT] && !async_cache_evicted && !light_clear
        |=> async_advance_doorbell) // R6
        else $error("doorbell write not recorded");
    chk_irq_boundary: assert property (@(posedge clk) disable iff (!resetn)
        $rose(host_irq) |-> $past(boundary) && $past(async_advance_flag && async_advance_irq_en)) // R12
        else $error("interrupt raised off a threshold boundary");
    chk_irq_assert: assert property (@(posedge clk) disable iff (!resetn)
        boundary && async_advance_flag && async_advance_irq_en |=> host_irq) // R8
        else $error("interrupt missing at boundary");

endmodule : ehci_command_irq_control

// [sim/sched_model.sv]
/*
 * Schedule engine model: microframe ticks, cache eviction and light reset completion.
 * Assumes one clock and the block's active-low asynchronous reset.
 */
`timescale 1ns/1ps
module sched_model (
    // Clock and reset
    input  wire logic clk,
    input  wire logic resetn,
    // Requests from the block, and the bench's wait-length select
    input  wire logic doorbell_pending,
    input  wire logic light_reset_req,
    input  wire logic slow,
    // Answers to the block
    output logic      uframe_tick,
    output logic      async_cache_evicted,
    output logic      light_reset_done
);
    logic [3:0] tick_cnt;
    logic [3:0] wait_cnt;
    logic [3:0] lim;

    assign lim = slow ? 4'h9 : 4'h2;

    // ==========================================================================
    // One tick every eight clocks keeps threshold boundaries short.
    // ==========================================================================
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            tick_cnt <= 4'h0;
            uframe_tick <= 1'b0;
        end
        else
        begin
            tick_cnt <= tick_cnt + 4'h1;
            uframe_tick <= (tick_cnt[2:0] == 3'h7);
        end
    end

    // ==========================================================================
    // Answers come after a short or long wait, one pulse per request.
    // ==========================================================================
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            wait_cnt <= 4'h0;
            async_cache_evicted <= 1'b0;
            light_reset_done <= 1'b0;
        end
        else
        begin
            wait_cnt <= (!(doorbell_pending | light_reset_req) || wait_cnt == lim) ? 4'h0 : wait_cnt + 4'h1;
            async_cache_evicted <= doorbell_pending && wait_cnt == lim;
            light_reset_done <= light_reset_req && wait_cnt == lim;
        end
    end
endmodule : sched_model

// [sim/testbench.sv]
/*
 * Self-checking bench: APB transfers against the command block and its engine model.
 * Assumes zero or more wait states and registers at the package offsets.
 */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
    $display("FAIL %s exp %h got %h", nm, e, g); end end
module testbench;
    import ehci_cmd_pkg::*;
    logic        clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, halted = 1, slow = 0, err;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, prdata_nolr, rd, rd_nolr;
    logic        pready, pslverr, tick, evicted, lr_done, db_pend, lr_req, host_irq;
    logic [7:0]  thr [7] = '{THR_1UF, THR_2UF, THR_4UF, THR_8UF, THR_16UF, THR_32UF, THR_64UF};
    int          mismatches = 0, checks_done = 0, n;

    always #25 clk = ~clk;

    ehci_command_irq_control dut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ctrl_halted_flag(halted), .async_cache_evicted(evicted), .uframe_tick(tick),
        .doorbell_pending(db_pend), .light_reset_req(lr_req), .light_reset_done(lr_done), .host_irq(host_irq));
    ehci_command_irq_control #(.LIGHT_RESET_IMPL(1'b0)) dut_nolr (.clk(clk), .resetn(resetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata_nolr), .pready(),
        .pslverr(), .ctrl_halted_flag(halted), .async_cache_evicted(evicted), .uframe_tick(tick),
        .doorbell_pending(), .light_reset_req(), .light_reset_done(lr_done), .host_irq());
    sched_model engine (.clk(clk), .resetn(resetn), .doorbell_pending(db_pend), .light_reset_req(lr_req),
        .slow(slow), .uframe_tick(tick), .async_cache_evicted(evicted), .light_reset_done(lr_done));

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // No wait-state count is assumed; a slave that never answers is caught by the watchdog.
        do begin @(posedge clk); end while (pready !== 1'b1);
        rd = prdata;
        rd_nolr = prdata_nolr;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic wait_irq(input int lim);
        n = 0;
        while (host_irq !== 1'b1 && n < lim) begin @(posedge clk); n++; end
    endtask : wait_irq

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish

    initial
    begin
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        apb(0, CMD_OFF, 0); `CHK("cmd reset", 32'h0008_0000, rd)
        foreach (thr[i])
        begin
            apb(1, CMD_OFF, {8'h00, thr[i], 16'h0000});
            apb(0, CMD_OFF, 0); `CHK("threshold", {8'h00, thr[i], 16'h0000}, rd)
        end
        apb(0, 8'h30, 0); `CHK("unmapped", 33'h1_0000_0000, {err, rd})
        apb(1, IRQ_EN_OFF, 32'h20);
        apb(1, CMD_OFF, {8'h00, THR_4UF, 16'h0040});
        wait_irq(45); `CHK("irq at boundary", 1'b1, host_irq)
        apb(0, STATUS_OFF, 0); `CHK("status", 32'h0000_1020, rd)
        apb(0, CMD_OFF, 0); `CHK("doorbell done", 1'b0, rd[DOORBELL_BIT])
        apb(1, STATUS_OFF, 32'h20);
        @(posedge clk); `CHK("irq cleared", 1'b0, host_irq)
        slow <= 1'b1;
        apb(1, IRQ_EN_OFF, 0);
        apb(1, CMD_OFF, {8'h00, THR_4UF, 16'h0040});
        repeat (100) @(posedge clk); `CHK("masked irq", 1'b0, host_irq)
        apb(0, STATUS_OFF, 0); `CHK("flag held", 32'h0000_1020, rd)
        apb(1, IRQ_EN_OFF, 32'h20);
        wait_irq(40); `CHK("held irq", 1'b1, host_irq)
        apb(1, CMD_OFF, {8'h00, THR_4UF, 16'h0080});
        apb(0, CMD_OFF, 0); `CHK("light busy", 1'b1, rd[LRESET_BIT])
        `CHK("light absent", 1'b0, rd_nolr[LRESET_BIT])
        repeat (20) @(posedge clk);
        apb(0, CMD_OFF, 0); `CHK("light done", 32'h0008_0000, rd)
        apb(0, STATUS_OFF, 0); `CHK("status after light", 32'h0000_1000, rd)
        `CHK("irq after light", 1'b0, host_irq)
        // The halted level must reach the status word, not a constant one.
        halted <= 1'b0;
        apb(0, STATUS_OFF, 0); `CHK("running status", 32'h0000_0000, rd)
        tally_and_finish;
    end

    initial
    begin
        repeat (3000) @(posedge clk);
        mismatches++;
        tally_and_finish;
    end
endmodule : testbench
